// *** common/gpf_pkg.sv ***
package gpf_pkg;
	// geometry
	localparam int GPF_MASTERS = 4;
	localparam int GPF_LVL_W = 8;

	// register byte offsets
	localparam logic [7:0] GPF_OFF_FUNC = 8'h00;
	localparam logic [7:0] GPF_OFF_ON = 8'h04;
	localparam logic [7:0] GPF_OFF_LP = 8'h08;
	localparam logic [7:0] GPF_OFF_SLEW = 8'h0C;
	localparam logic [7:0] GPF_OFF_STUP = 8'h10;
	localparam logic [7:0] GPF_OFF_DFLT = 8'h14;
	localparam logic [7:0] GPF_OFF_SLEEP = 8'h18;
	localparam logic [7:0] GPF_OFF_NORM = 8'h1C;
	localparam logic [7:0] GPF_OFF_STAT = 8'h20;
	localparam logic [7:0] GPF_OFF_LVL = 8'h24;

	// field positions
	localparam int GPF_FUNC_A_LSB = 0;
	localparam int GPF_FUNC_B_LSB = 4;
	localparam int GPF_RISE_LSB = 0;
	localparam int GPF_FALL_LSB = 4;
	localparam int GPF_ST_EN_LSB = 0;
	localparam int GPF_ST_LP_LSB = 4;
	localparam int GPF_ST_GOOD_LSB = 8;
	localparam int GPF_ST_SS_LSB = 12;
	localparam int GPF_ST_STRAP_LSB = 16;

	// values after reset
	localparam logic [3:0] GPF_FUNC_RST = 4'hF;
	localparam logic [2:0] GPF_SLEW_RST = 3'h2;
	localparam logic [31:0] GPF_LVL_RST = 32'h8C8C8C8C;
	localparam logic [31:0] GPF_STUP_RST = 32'h03020100;

	// pin function codes
	localparam logic [3:0] GPF_FN_ALL_MASTERS_ON = 4'h0;
	localparam logic [3:0] GPF_FN_EN_BASE = 4'h1;
	localparam logic [3:0] GPF_FN_VSEL = 4'h5;
	localparam logic [3:0] GPF_FN_GLB_LP = 4'hA;
	localparam logic [3:0] GPF_FN_LP_BASE = 4'hB;

	// timing: clock, output step, slew rates in units of 0.01 mV/us
	localparam int GPF_CLK_NS = 50;
	localparam int GPF_STEP_MV_X100 = 500;
	localparam int GPF_RATE_X100 [8] = '{125, 250, 500, 1000, 2000, 4000,
		6000, 6000};
	localparam int GPF_STUP_TICK_NS = 1000;
	localparam int GPF_STUP_TICK_CYC = GPF_STUP_TICK_NS / GPF_CLK_NS;
	localparam logic [1:0] GPF_STRAP_WAIT = 2'h3;

	// per-master outputs towards the power stage
	typedef struct packed {
		logic enable;
		logic lowpower;
		logic boost_en;
		logic deadtime_en;
		logic good;
		logic soft_done;
		logic [GPF_LVL_W-1:0] level;
	} gpf_master_s;

	// cycles per output step for a slew selection (shorter time: floor)
	function automatic logic [6:0] gpf_step_cyc(input logic [2:0] sel);
		int c;
		c = (GPF_STEP_MV_X100 * 1000) / (GPF_RATE_X100[sel] * GPF_CLK_NS);
		if (c < 1) begin
			c = 1;
		end
		return c[6:0];
	endfunction
endpackage

// *** design/gpf_core.sv ***
`timescale 1ns/1ps
module gpf_core (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// ahb-lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// pins and analogue status
	input wire logic ctrl_pin_a_in,
	input wire logic ctrl_pin_b_in,
	input wire logic phase_strap_0_in,
	input wire logic phase_strap_1_in,
	input wire logic phase_strap_2_in,
	input wire logic [gpf_pkg::GPF_MASTERS-1:0] below_thresh_in,
	// power stage control
	output gpf_pkg::gpf_master_s [gpf_pkg::GPF_MASTERS-1:0] master_out,
	output logic [7:0] phase_owner_out
);
	import gpf_pkg::*;

	localparam int NS = 9;

	logic [NS-1:0] sync1_q, sync2_q, sync3_q, filt_q;
	logic pin_a, pin_b;
	logic [2:0] strap_q;
	logic [1:0] strap_cnt_q;
	logic strap_done_q;
	logic [3:0] master_valid_q;
	logic [3:0] func_a_q, func_b_q;
	logic [3:0] on_bits_q, lp_bits_q;
	logic [2:0] rise_q, fall_q;
	logic [31:0] stup_q, dflt_q, sleep_q, norm_q;
	logic pend_q, pend_wr_q;
	logic [7:0] pend_addr_q;
	logic [31:0] rdata;
	logic all_masters_on, glb_lp, vsel_used, vsel;
	logic [7:0] tick_cnt_q;
	logic [4:0] tick_div_q;
	logic [3:0] st_en, st_lp, st_good, st_ss;
	logic [31:0] lvl_word;

	// three-stage synchronisers for pins, comparators and straps
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			filt_q <= '0;
		end else begin
			sync1_q <= {phase_strap_2_in, phase_strap_1_in, phase_strap_0_in,
				below_thresh_in, ctrl_pin_b_in, ctrl_pin_a_in};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			filt_q <= (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));
		end
	end

	assign pin_a = filt_q[0];
	assign pin_b = filt_q[1];

	// straps caught once after reset release, then held
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			strap_cnt_q <= '0;
			strap_done_q <= 1'b0;
			strap_q <= '0;
		end else if (!strap_done_q) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			if (strap_cnt_q == GPF_STRAP_WAIT) begin
				// filter stage is one edge late here; the two late stages agree
				strap_q <= sync2_q[8:6] & sync3_q[8:6];
				strap_done_q <= 1'b1;
			end
		end
	end

	// phase-to-master mapping and which masters exist
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			master_valid_q <= '0;
			phase_owner_out <= '0;
		end else begin
			case (strap_q)
			3'h1: begin
				master_valid_q <= 4'h7;
				phase_owner_out <= 8'h90;
			end
			3'h2: begin
				master_valid_q <= 4'h3;
				phase_owner_out <= 8'h50;
			end
			3'h3: begin
				master_valid_q <= 4'h3;
				phase_owner_out <= 8'h40;
			end
			3'h4: begin
				master_valid_q <= 4'h1;
				phase_owner_out <= 8'h00;
			end
			default: begin
				master_valid_q <= 4'hF;
				phase_owner_out <= 8'hE4;
			end
			endcase
			if (!strap_done_q) begin
				master_valid_q <= '0;
			end
		end
	end

	// bus address phase is taken, then one wait cycle, then the answer
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			pend_q <= 1'b0;
			pend_wr_q <= 1'b0;
			pend_addr_q <= '0;
			hreadyout_out <= 1'b1;
			hrdata_out <= '0;
			hresp_out <= 1'b0;
		end else if (pend_q) begin
			pend_q <= 1'b0;
			hreadyout_out <= 1'b1;
			hrdata_out <= pend_wr_q ? 32'h00000000 : rdata;
		end else if (hsel_in && htrans_in[1] && hready_in) begin
			pend_q <= 1'b1;
			pend_wr_q <= hwrite_in;
			pend_addr_q <= haddr_in[7:0];
			hreadyout_out <= 1'b0;
		end
	end

	// register writes in the data phase; unmapped writes are dropped
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			func_a_q <= GPF_FUNC_RST;
			func_b_q <= GPF_FUNC_RST;
			on_bits_q <= '0;
			lp_bits_q <= '0;
			rise_q <= GPF_SLEW_RST;
			fall_q <= GPF_SLEW_RST;
			stup_q <= GPF_STUP_RST;
			dflt_q <= GPF_LVL_RST;
			sleep_q <= GPF_LVL_RST;
			norm_q <= GPF_LVL_RST;
		end else if (pend_q && pend_wr_q) begin
			case (pend_addr_q)
			GPF_OFF_FUNC: begin
				func_a_q <= hwdata_in[GPF_FUNC_A_LSB +: 4];
				func_b_q <= hwdata_in[GPF_FUNC_B_LSB +: 4];
			end
			GPF_OFF_ON: on_bits_q <= hwdata_in[3:0];
			GPF_OFF_LP: lp_bits_q <= hwdata_in[3:0];
			GPF_OFF_SLEW: begin
				rise_q <= hwdata_in[GPF_RISE_LSB +: 3];
				fall_q <= hwdata_in[GPF_FALL_LSB +: 3];
			end
			GPF_OFF_STUP: stup_q <= hwdata_in;
			GPF_OFF_DFLT: dflt_q <= hwdata_in;
			GPF_OFF_SLEEP: sleep_q <= hwdata_in;
			GPF_OFF_NORM: norm_q <= hwdata_in;
			default: ;
			endcase
		end
	end

	// read mux; reserved bits and unmapped offsets read zero
	always_comb begin
		rdata = '0;
		case (pend_addr_q)
		GPF_OFF_FUNC: rdata = {24'h000000, func_b_q, func_a_q};
		GPF_OFF_ON: rdata = {28'h0000000, on_bits_q};
		GPF_OFF_LP: rdata = {28'h0000000, lp_bits_q};
		GPF_OFF_SLEW: rdata = {25'h0000000, fall_q, 1'b0, rise_q};
		GPF_OFF_STUP: rdata = stup_q;
		GPF_OFF_DFLT: rdata = dflt_q;
		GPF_OFF_SLEEP: rdata = sleep_q;
		GPF_OFF_NORM: rdata = norm_q;
		GPF_OFF_STAT: begin
			rdata[GPF_ST_EN_LSB +: 4] = st_en;
			rdata[GPF_ST_LP_LSB +: 4] = st_lp;
			rdata[GPF_ST_GOOD_LSB +: 4] = st_good;
			rdata[GPF_ST_SS_LSB +: 4] = st_ss;
			rdata[GPF_ST_STRAP_LSB +: 3] = strap_q;
		end
		GPF_OFF_LVL: rdata = lvl_word;
		default: rdata = '0;
		endcase
	end

	// global functions: either pin carrying the code drives it
	assign all_masters_on = (pin_a && func_a_q == GPF_FN_ALL_MASTERS_ON)
		|| (pin_b && func_b_q == GPF_FN_ALL_MASTERS_ON);
	assign glb_lp = (pin_a && func_a_q == GPF_FN_GLB_LP)
		|| (pin_b && func_b_q == GPF_FN_GLB_LP);
	assign vsel_used = func_a_q == GPF_FN_VSEL || func_b_q == GPF_FN_VSEL;
	assign vsel = (pin_a && func_a_q == GPF_FN_VSEL)
		|| (pin_b && func_b_q == GPF_FN_VSEL);

	// startup sequence timer, restarts whenever global enable drops
	always_ff @(posedge ref_clk_in) begin
		if (reset_in || !all_masters_on) begin
			tick_div_q <= '0;
			tick_cnt_q <= '0;
		end else if (tick_div_q == 5'(GPF_STUP_TICK_CYC - 1)) begin
			tick_div_q <= '0;
			if (tick_cnt_q != 8'hFF) begin
				tick_cnt_q <= tick_cnt_q + 8'h01;
			end
		end else begin
			tick_div_q <= tick_div_q + 5'h01;
		end
	end

	// per-master enable, low power, ramp and good logic
	genvar gi;
	generate
		for (gi = 0; gi < GPF_MASTERS; gi++) begin : g_m
			logic pin_en, pin_lp, en, lp, seq_on, good_q, good_d, ss_q;
			logic [GPF_LVL_W-1:0] target, level_q;
			logic [6:0] step_cnt_q, step_lim;

			// codes outside the defined set match nothing here
			assign pin_en = (pin_a && func_a_q == 4'(GPF_FN_EN_BASE + gi))
				|| (pin_b && func_b_q == 4'(GPF_FN_EN_BASE + gi));
			assign pin_lp = (pin_a && func_a_q == 4'(GPF_FN_LP_BASE + gi))
				|| (pin_b && func_b_q == 4'(GPF_FN_LP_BASE + gi));
			assign seq_on = all_masters_on && tick_cnt_q >= stup_q[gi*8 +: 8];
			assign en = master_valid_q[gi]
				&& (on_bits_q[gi] || pin_en || seq_on);
			assign lp = lp_bits_q[gi] || pin_lp || glb_lp;
			assign target = !vsel_used ? norm_q[gi*8 +: 8]
				: vsel ? dflt_q[gi*8 +: 8] : sleep_q[gi*8 +: 8];
			assign step_lim = (level_q < target) ? gpf_step_cyc(rise_q)
				: gpf_step_cyc(fall_q);

			// one 5 mV step each time the slew counter expires
			always_ff @(posedge ref_clk_in) begin
				if (reset_in || !en) begin
					level_q <= '0;
					step_cnt_q <= '0;
					ss_q <= 1'b0;
				end else if (level_q == target) begin
					step_cnt_q <= '0;
					ss_q <= 1'b1;
				end else if (step_cnt_q >= step_lim - 7'h01) begin
					step_cnt_q <= '0;
					level_q <= (level_q < target) ? level_q + 8'h01
						: level_q - 8'h01;
				end else begin
					step_cnt_q <= step_cnt_q + 7'h01;
				end
			end

			// good flag: high in low power, else comparator when active;
			// one next value feeds flag and output so they stay aligned
			assign good_d = (en && lp) ? 1'b1
				: (en && ss_q) ? filt_q[2 + gi] : 1'b0;
			always_ff @(posedge ref_clk_in) begin
				if (reset_in) begin
					good_q <= 1'b0;
				end else begin
					good_q <= good_d;
				end
			end

			// registered outputs to the power stage
			always_ff @(posedge ref_clk_in) begin
				if (reset_in) begin
					master_out[gi] <= '0;
				end else begin
					master_out[gi].enable <= en;
					master_out[gi].lowpower <= en && lp;
					master_out[gi].boost_en <= en && !lp;
					master_out[gi].deadtime_en <= en && !lp;
					master_out[gi].good <= good_d;
					master_out[gi].soft_done <= ss_q;
					master_out[gi].level <= level_q;
				end
			end

			assign st_en[gi] = en;
			assign st_lp[gi] = en && lp;
			assign st_good[gi] = good_q;
			assign st_ss[gi] = ss_q;
			assign lvl_word[gi*8 +: 8] = level_q;
		end
	endgenerate
endmodule

// *** verification/gpf_core_checker.sv ***
`timescale 1ns/1ps
module gpf_core_checker (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// bus
	input wire logic hsel_in,
	input wire logic [1:0] htrans_in,
	input wire logic hready_in,
	input wire logic hreadyout_out,
	input wire logic hresp_out,
	// power stage
	input gpf_pkg::gpf_master_s [gpf_pkg::GPF_MASTERS-1:0] master_out,
	input wire logic [7:0] phase_owner_out
);
	import gpf_pkg::*;
	logic [3:0] up_q;
	gpf_master_s m;
	assign m = master_out[0];
	// cycles since reset, saturating
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			up_q <= 4'h0;
		end else if (up_q != 4'hF) begin
			up_q <= up_q + 4'h1;
		end
	end
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (reset_in);
	// bus answers after exactly one wait state
	chk_bus_wait: assert property (
		hsel_in && htrans_in[1] && hready_in
		|=> !hreadyout_out ##1 hreadyout_out) else $error("bus wait wrong");
	chk_resp_okay: assert property (!hresp_out)
		else $error("bus response not okay");
	// low power forces good high and switches helpers off
	chk_lp_good: assert property (
		m.lowpower && m.enable |-> m.good)
		else $error("good low in low power");
	chk_lp_off: assert property (
		m.lowpower |-> !m.boost_en && !m.deadtime_en)
		else $error("boost or deadtime on in low power");
	chk_good_cause: assert property (
		m.good && !m.lowpower |-> m.enable && m.soft_done)
		else $error("good without cause");
	// master 0 may not start before the straps are caught
	chk_early_off: assert property (
		up_q < 4'h4 |-> m == '0)
		else $error("master active right after reset");
	chk_ramp_step: assert property (
		$changed(m.level) && m.enable && $past(m.enable)
		|-> (m.level - $past(m.level) == 8'h01)
		|| ($past(m.level) - m.level == 8'h01)) else $error("level jumped");
	chk_owner_hold: assert property (
		up_q == 4'hF |-> $stable(phase_owner_out))
		else $error("phase owner changed");
	cover property (m.enable && m.soft_done);
	cover property (m.lowpower && m.enable);
	cover property (m.good && !m.lowpower);
endmodule

bind gpf_core gpf_core_checker u_chk (
	.ref_clk_in(ref_clk_in),
	.reset_in(reset_in),
	.hsel_in(hsel_in),
	.htrans_in(htrans_in),
	.hready_in(hready_in),
	.hreadyout_out(hreadyout_out),
	.hresp_out(hresp_out),
	.master_out(master_out),
	.phase_owner_out(phase_owner_out)
);

// *** verification/gpf_core_tb.sv ***
`timescale 1ns/1ps
module gpf_core_tb;
	import gpf_pkg::*;
	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] want = 2'h0;
	logic [3:0] below = 4'h0;
	logic [2:0] strap = 3'h0;
	logic [31:0] hrdata, v;
	logic hready, hresp, pin_a, pin_b;
	gpf_master_s [GPF_MASTERS-1:0] mo;
	logic [7:0] own;
	int n_errors = 0;
	int n_compared = 0;
	always #25 ref_clk_in = ~ref_clk_in;
	gpf_host_model u_host (.ref_clk_in(ref_clk_in), .want_in(want),
		.ctrl_pin_a_out(pin_a), .ctrl_pin_b_out(pin_b));
	gpf_core u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
		.hresp_out(hresp), .ctrl_pin_a_in(pin_a), .ctrl_pin_b_in(pin_b),
		.phase_strap_0_in(strap[0]), .phase_strap_1_in(strap[1]),
		.phase_strap_2_in(strap[2]), .below_thresh_in(below),
		.master_out(mo), .phase_owner_out(own));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("Error at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	// one single word transfer, read data left in v
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge ref_clk_in);
		while (hready !== 1'b1) @(posedge ref_clk_in);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge ref_clk_in);
		while (hready !== 1'b1) @(posedge ref_clk_in);
		v = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic pins(input logic [1:0] p);
		want <= p;
		wt(12);
	endtask
	task automatic t_reset;
		rd(GPF_OFF_FUNC);
		chk(v, 32'h000000FF);
		chk(32'(hresp), 32'h0);
		rd(GPF_OFF_SLEW);
		chk(v, 32'h00000022);
		wr(GPF_OFF_SLEW, 32'hFFFFFFFF);
		rd(GPF_OFF_SLEW);
		chk(v, 32'h00000077);
		rd(GPF_OFF_STAT);
		chk(v, 32'h0);
		chk(32'(own), 32'hE4);
		chk(32'(mo[1:0]), 32'h0);
		chk(32'(mo[3:2]), 32'h0);
		rd(8'h3C);
		chk(v, 32'h0);
	endtask
	task automatic t_enable;
		wr(GPF_OFF_FUNC, 32'hF1);
		pins(2'b01);
		rd(GPF_OFF_STAT);
		chk(32'(v[3:0]), 32'h1);
		chk(32'(mo[0].enable), 32'h1);
		pins(2'b00);
		wr(GPF_OFF_ON, 32'h1);
		rd(GPF_OFF_STAT);
		chk(32'(v[3:0]), 32'h1);
		wr(GPF_OFF_ON, 32'h0);
		wr(GPF_OFF_FUNC, 32'h22);
		pins(2'b10);
		rd(GPF_OFF_STAT);
		chk(32'(v[3:0]), 32'h2);
		chk(32'(mo[1].enable), 32'h1);
		pins(2'b01);
		rd(GPF_OFF_STAT);
		chk(32'(v[3:0]), 32'h2);
		pins(2'b00);
		rd(GPF_OFF_STAT);
		chk(32'(v[3:0]), 32'h0);
		chk(32'(mo[1].enable), 32'h0);
	endtask
	task automatic t_undef;
		logic [3:0] c [5] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'hF};
		pins(2'b11);
		for (int i = 0; i < 5; i++) begin
			wr(GPF_OFF_FUNC, {24'h0, c[i], c[i]});
			wt(8);
			rd(GPF_OFF_STAT);
			chk(32'(v[7:0]), 32'h0);
		end
		pins(2'b00);
	endtask
	task automatic t_lowpower;
		wr(GPF_OFF_ON, 32'hF);
		wr(GPF_OFF_FUNC, 32'hFB);
		pins(2'b01);
		rd(GPF_OFF_STAT);
		chk(32'(v[7:4]), 32'h1);
		wr(GPF_OFF_FUNC, 32'hCC);
		pins(2'b10);
		rd(GPF_OFF_STAT);
		chk(32'(v[7:4]), 32'h2);
		wr(GPF_OFF_FUNC, 32'hFA);
		pins(2'b01);
		rd(GPF_OFF_STAT);
		chk(32'(v[7:4]), 32'hF);
		chk(32'(v[11:8]), 32'hF);
		chk(32'({mo[0].lowpower, mo[0].boost_en, mo[0].deadtime_en,
			mo[0].good}), 32'h9);
		wr(GPF_OFF_LP, 32'h8);
		pins(2'b00);
		rd(GPF_OFF_STAT);
		chk(32'(v[7:4]), 32'h8);
		wr(GPF_OFF_LP, 32'h0);
		wr(GPF_OFF_ON, 32'h0);
	endtask
	// quick rise, slowest fall
	task automatic t_level;
		wr(GPF_OFF_SLEW, 32'h06);
		wr(GPF_OFF_DFLT, 32'h10);
		wr(GPF_OFF_SLEEP, 32'h08);
		wr(GPF_OFF_FUNC, 32'h55);
		wr(GPF_OFF_ON, 32'h1);
		pins(2'b01);
		wt(40);
		rd(GPF_OFF_LVL);
		chk(32'(v[7:0]), 32'h10);
		pins(2'b00);
		wt(40);
		rd(GPF_OFF_LVL);
		chk(32'(v[7:0] > 8'h08), 32'h1);
		wt(700);
		rd(GPF_OFF_LVL);
		chk(32'(v[7:0]), 32'h08);
		pins(2'b10);
		wt(40);
		rd(GPF_OFF_LVL);
		chk(32'(v[7:0]), 32'h10);
		chk(32'(mo[0].level), 32'h10);
		below <= 4'h1;
		wt(8);
		rd(GPF_OFF_STAT);
		chk(32'(v[11:8]), 32'h1);
		chk(32'(mo[0].good), 32'h1);
		wr(GPF_OFF_ON, 32'h0);
		rd(GPF_OFF_STAT);
		chk(32'(v[11:8]), 32'h0);
		below <= 4'h0;
		pins(2'b00);
	endtask
	task automatic t_global;
		wr(GPF_OFF_STUP, 32'h30201000);
		wr(GPF_OFF_FUNC, 32'hF0);
		pins(2'b01);
		wt(400);
		rd(GPF_OFF_STAT);
		chk(32'(v[3:0]), 32'h3);
		wt(700);
		rd(GPF_OFF_STAT);
		chk(32'(v[3:0]), 32'hF);
		pins(2'b00);
	endtask
	// straps for a single master, taken again through a second reset
	task automatic t_strap;
		strap <= 3'h4;
		reset_in <= 1'b1;
		wt(16);
		reset_in <= 1'b0;
		wt(12);
		rd(GPF_OFF_STAT);
		chk(32'(v[18:16]), 32'h4);
		chk(32'(own), 32'h0);
		wr(GPF_OFF_ON, 32'hF);
		rd(GPF_OFF_STAT);
		chk(32'(v[3:0]), 32'h1);
		wr(GPF_OFF_ON, 32'h0);
	endtask
	task automatic give_verdict;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		wt(16);
		reset_in <= 1'b0;
		wt(12);
		t_reset;
		t_enable;
		t_undef;
		t_lowpower;
		t_level;
		t_global;
		t_strap;
		give_verdict;
	end
	// cut a hang short
	initial begin
		#(50 * 10000);
		n_errors++;
		give_verdict;
	end
endmodule

// *** verification/gpf_host_model.sv ***
`timescale 1ns/1ps
module gpf_host_model (
	// clock
	input wire logic ref_clk_in,
	// wanted pin levels
	input wire logic [1:0] want_in,
	// control pins
	output logic ctrl_pin_a_out,
	output logic ctrl_pin_b_out
);
	// pins move just after an edge, unrelated to bus traffic
	always_ff @(posedge ref_clk_in) begin
		ctrl_pin_a_out <= want_in[0];
		ctrl_pin_b_out <= want_in[1];
	end
endmodule
